// ---- design/eas_pkg.sv ----
// constants and types for the event action sequencer
// Function
// - events and actions sit in indexed arrays; pair n forms state n
// - a true event of the current state fires its paired action
// - after an action the next state's event becomes the tested one
// - one event tested per scan tick; false means nothing happens
// - at start only the first event is tested until it is true
// - table holds zero to twenty programmed pairs
// - after the last pair the sequence wraps to the first pair
// - event codes: 0 false, 1 true, 4 on reference, 30 timer zero done
// - action codes: 1 none, 10 preset zero, 11 preset one, 29 start timer
// - sequencer runs only while run setting equals one
// - timer zero holds a programmable duration, e.g. two seconds
package eas_pkg;
   localparam int unsigned MAX_PAIRS = 20;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned CODE_W = 8;
   // register map, word aligned byte offsets
   localparam logic [7:0] OFF_RUN = 8'h00;
   localparam logic [7:0] OFF_COUNT = 8'h04;
   localparam logic [7:0] OFF_TIMER = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_EVENT_BASE = 8'h40;
   localparam logic [7:0] OFF_ACTION_BASE = 8'h90;
   localparam logic [7:0] OFF_TABLE_SPAN = 8'h50;
   // event codes
   localparam logic [7:0] EV_FALSE = 8'h00;
   localparam logic [7:0] EV_TRUE = 8'h01;
   localparam logic [7:0] EV_ON_REF = 8'h04;
   localparam logic [7:0] EV_TIMEOUT0 = 8'h1e;
   // action codes
   localparam logic [7:0] ACT_NONE = 8'h01;
   localparam logic [7:0] ACT_PRESET0 = 8'h0a;
   localparam logic [7:0] ACT_PRESET1 = 8'h0b;
   localparam logic [7:0] ACT_START_T0 = 8'h1d;
   localparam logic [7:0] RUN_ON = 8'h01;
   // timer zero counts in milliseconds; 2 s example
   localparam int unsigned CLK_HZ = 100000000;
   localparam int unsigned MS_PERIOD_NS = 1000000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [31:0] TIMER_RESET_MS = 32'h000007d0;
   localparam int unsigned SCAN_CYCLES_DEF = 100000;
endpackage

// ---- design/eas_tick_div.sv ----
// enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module eas_tick_div #(
   parameter int unsigned DIV = 100
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pulse out
   output logic tick
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } eas_div_t;
   eas_div_t st_reg, st_next;
   // count down and pulse at zero
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.cnt == 32'h0) begin
         st_next.cnt = 32'(DIV - 1);
         st_next.tick = 1'b1;
      end else begin
         st_next.cnt = st_reg.cnt - 32'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign tick = st_reg.tick;
endmodule
`default_nettype wire

// ---- design/eas_sync3.sv ----
// three stage input synchroniser
`timescale 1ns/10ps
`default_nettype none
module eas_sync3 (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in and filtered out
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } eas_sync_t;
   eas_sync_t st_reg, st_next;
   // change accepted once stage two and three agree; stage one feeds only two
   always_comb begin
      st_next = st_reg;
      st_next.s1 = din;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      if (st_reg.s2 == st_reg.s3) begin
         st_next.q = st_reg.s3;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign dout = st_reg.q;
endmodule
`default_nettype wire

// ---- design/eas_sequencer.sv ----
// event action sequencer with wishbone register file
`timescale 1ns/10ps
`default_nettype none
module eas_sequencer #(
   parameter int unsigned SCAN_CYCLES = eas_pkg::SCAN_CYCLES_DEF,
   parameter int unsigned MS_CYCLES = eas_pkg::MS_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // drive status
   input wire logic onReference,
   // drive commands
   output logic presetSel,
   output logic presetStrobe,
   output logic timerRunning,
   output logic actionPulse,
   output logic [4:0] stateIndex
);
   ////////////////////////////////////////////////////////////////
   // state
   typedef enum logic [1:0] {
      EAS_IDLE = 2'b00,
      EAS_RUN = 2'b01
   } eas_mode_t;
   typedef struct packed {
      eas_mode_t mode;
      logic [7:0] runSetting;
      logic [4:0] pairCount;
      logic [31:0] timerDuration;
      logic [4:0] idx;
      logic [31:0] msLeft;
      logic [31:0] cycLeft;
      logic timerOn;
      logic timerDone;
      logic presetSel;
      logic presetStrobe;
      logic actionPulse;
      logic ack;
      logic [31:0] rdata;
   } eas_st_t;
   eas_st_t st_reg, st_next;
   logic [7:0] eventCondArray [0:eas_pkg::MAX_PAIRS-1];
   logic [7:0] actionCmdArray [0:eas_pkg::MAX_PAIRS-1];
   logic scanTick;
   logic onRefSync;
   logic busReq;
   logic busWrite;
   logic [7:0] evIdxAddr;
   logic [7:0] acIdxAddr;
   logic evHit;
   logic acHit;
   logic evTrue;
   logic [7:0] curEvent;
   logic [7:0] curAction;
   logic timerExpire;
   ////////////////////////////////////////////////////////////////
   // submodules
   eas_tick_div #(.DIV(SCAN_CYCLES)) uScan (
      .clk(clk),
      .rst_n(rst_n),
      .tick(scanTick)
   );
   eas_sync3 uRefSync (
      .clk(clk),
      .rst_n(rst_n),
      .din(onReference),
      .dout(onRefSync)
   );
   ////////////////////////////////////////////////////////////////
   // bus decode; one wait state, ack in second cycle
   assign busReq = wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign busWrite = busReq && wb_we_i && wb_sel_i[0];
   assign evIdxAddr = 8'((wb_adr_i - eas_pkg::OFF_EVENT_BASE) >> 2);
   assign acIdxAddr = 8'((wb_adr_i - eas_pkg::OFF_ACTION_BASE) >> 2);
   assign evHit = (wb_adr_i >= eas_pkg::OFF_EVENT_BASE)
      && (wb_adr_i < eas_pkg::OFF_EVENT_BASE + eas_pkg::OFF_TABLE_SPAN)
      && (wb_adr_i[1:0] == 2'b00);
   assign acHit = (wb_adr_i >= eas_pkg::OFF_ACTION_BASE)
      && (wb_adr_i < eas_pkg::OFF_ACTION_BASE + eas_pkg::OFF_TABLE_SPAN)
      && (wb_adr_i[1:0] == 2'b00);
   // table writes, byte lane zero only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < eas_pkg::MAX_PAIRS; i++) begin
            eventCondArray[i] <= eas_pkg::EV_FALSE;
            actionCmdArray[i] <= eas_pkg::ACT_NONE;
         end
      end else if (busWrite) begin
         if (evHit) begin
            eventCondArray[evIdxAddr[4:0]] <= wb_dat_i[7:0];
         end
         if (acHit) begin
            actionCmdArray[acIdxAddr[4:0]] <= wb_dat_i[7:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // event decode
   assign curEvent = eventCondArray[st_reg.idx];
   assign curAction = actionCmdArray[st_reg.idx];
   // expiry in this cycle; a restart landing on it still leaves done set
   assign timerExpire = st_reg.timerOn && (st_reg.cycLeft == 32'h0)
      && (st_reg.msLeft <= 32'h1);
   always_comb begin
      case (curEvent)
         eas_pkg::EV_FALSE: evTrue = 1'b0;
         eas_pkg::EV_TRUE: evTrue = 1'b1;
         eas_pkg::EV_ON_REF: evTrue = onRefSync;
         eas_pkg::EV_TIMEOUT0: evTrue = st_reg.timerDone;
         default: evTrue = 1'b0;
      endcase
   end
   ////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_next = st_reg;
      st_next.presetStrobe = 1'b0;
      st_next.actionPulse = 1'b0;
      st_next.ack = busReq;
      // register reads
      st_next.rdata = 32'h0;
      if (busReq && !wb_we_i) begin
         if (wb_adr_i == eas_pkg::OFF_RUN) begin
            st_next.rdata = {24'h0, st_reg.runSetting};
         end else if (wb_adr_i == eas_pkg::OFF_COUNT) begin
            st_next.rdata = {27'h0, st_reg.pairCount};
         end else if (wb_adr_i == eas_pkg::OFF_TIMER) begin
            st_next.rdata = st_reg.timerDuration;
         end else if (wb_adr_i == eas_pkg::OFF_STATUS) begin
            st_next.rdata = {22'h0, st_reg.timerDone, st_reg.timerOn,
               st_reg.presetSel, st_reg.mode == EAS_RUN, 1'b0, st_reg.idx};
         end else if (evHit) begin
            st_next.rdata = {24'h0, eventCondArray[evIdxAddr[4:0]]};
         end else if (acHit) begin
            st_next.rdata = {24'h0, actionCmdArray[acIdxAddr[4:0]]};
         end
      end
      // control writes; count clipped to twenty
      if (busWrite) begin
         if (wb_adr_i == eas_pkg::OFF_RUN) begin
            st_next.runSetting = wb_dat_i[7:0];
         end else if (wb_adr_i == eas_pkg::OFF_COUNT) begin
            if (wb_dat_i[7:0] > 8'(eas_pkg::MAX_PAIRS)) begin
               st_next.pairCount = 5'(eas_pkg::MAX_PAIRS);
            end else begin
               st_next.pairCount = wb_dat_i[4:0];
            end
         end
      end
      if (busReq && wb_we_i && wb_adr_i == eas_pkg::OFF_TIMER && wb_sel_i == 4'hf) begin
         st_next.timerDuration = wb_dat_i;
      end
      if (st_reg.timerOn) begin
         if (st_reg.cycLeft == 32'h0) begin
            st_next.cycLeft = 32'(MS_CYCLES - 1);
            if (st_reg.msLeft <= 32'h1) begin
               st_next.timerOn = 1'b0;
               st_next.timerDone = 1'b1;
            end else begin
               st_next.msLeft = st_reg.msLeft - 32'h1;
            end
         end else begin
            st_next.cycLeft = st_reg.cycLeft - 32'h1;
         end
      end
      case (st_reg.mode)
         EAS_IDLE: begin
            st_next.idx = 5'h0;
            if (st_reg.runSetting == eas_pkg::RUN_ON && st_reg.pairCount != 5'h0) begin
               st_next.mode = EAS_RUN;
            end
         end
         EAS_RUN: begin
            if (st_reg.runSetting != eas_pkg::RUN_ON || st_reg.pairCount == 5'h0) begin
               st_next.mode = EAS_IDLE;
               st_next.idx = 5'h0;
            // single test on the scan tick
            end else if (scanTick && evTrue) begin
               st_next.actionPulse = 1'b1;
               case (curAction)
                  eas_pkg::ACT_PRESET0: begin
                     st_next.presetSel = 1'b0;
                     st_next.presetStrobe = 1'b1;
                  end
                  eas_pkg::ACT_PRESET1: begin
                     st_next.presetSel = 1'b1;
                     st_next.presetStrobe = 1'b1;
                  end
                  eas_pkg::ACT_START_T0: begin
                     st_next.timerOn = st_reg.timerDuration != 32'h0;
                     st_next.timerDone = (st_reg.timerDuration == 32'h0) || timerExpire;
                     st_next.msLeft = st_reg.timerDuration;
                     st_next.cycLeft = 32'(MS_CYCLES - 1);
                  end
                  default: begin
                  end
               endcase
               if (st_reg.idx >= st_reg.pairCount - 5'h1) begin
                  st_next.idx = 5'h0;
               end else begin
                  st_next.idx = st_reg.idx + 5'h1;
               end
            end
         end
         default: begin
            st_next.mode = EAS_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.timerDuration <= eas_pkg::TIMER_RESET_MS;
      end else begin
         st_reg <= st_next;
      end
   end
   ////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign wb_ack_o = st_reg.ack;
   assign wb_dat_o = st_reg.rdata;
   assign presetSel = st_reg.presetSel;
   assign presetStrobe = st_reg.presetStrobe;
   assign timerRunning = st_reg.timerOn;
   assign actionPulse = st_reg.actionPulse;
   assign stateIndex = st_reg.idx;
   ////////////////////////////////////////////////////////////////
   // checks
   property p_act_on_tick;
      @(posedge clk) disable iff (!rst_n)
      actionPulse |-> $past(scanTick);
   endproperty
   a_act_on_tick: assert property (p_act_on_tick) else $error("action off scan tick");
   property p_no_act_false;
      @(posedge clk) disable iff (!rst_n)
      (scanTick && !evTrue) |=> !actionPulse;
   endproperty
   a_no_act_false: assert property (p_no_act_false) else $error("action on false event");
   property p_advance;
      @(posedge clk) disable iff (!rst_n)
      actionPulse && st_reg.mode == EAS_RUN && st_reg.pairCount > 5'h1 |->
         stateIndex != $past(stateIndex);
   endproperty
   a_advance: assert property (p_advance) else $error("index did not move");
   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      !actionPulse && st_reg.mode == EAS_RUN && $past(st_reg.mode) == EAS_RUN |->
         $stable(stateIndex);
   endproperty
   a_hold: assert property (p_hold) else $error("index moved without action");
   property p_wrap;
      @(posedge clk) disable iff (!rst_n)
      (scanTick && evTrue && st_reg.mode == EAS_RUN && st_reg.runSetting == eas_pkg::RUN_ON
         && st_reg.idx == st_reg.pairCount - 5'h1) |=> stateIndex == 5'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no wrap after last pair");
   property p_idle_first;
      @(posedge clk) disable iff (!rst_n)
      st_reg.mode == EAS_IDLE |=> stateIndex == 5'h0;
   endproperty
   a_idle_first: assert property (p_idle_first) else $error("idle index not zero");
   property p_run_gate;
      @(posedge clk) disable iff (!rst_n)
      st_reg.runSetting != eas_pkg::RUN_ON |=> !actionPulse;
   endproperty
   a_run_gate: assert property (p_run_gate) else $error("action while off");
   property p_count_max;
      @(posedge clk) disable iff (!rst_n)
      st_reg.pairCount <= 5'(eas_pkg::MAX_PAIRS);
   endproperty
   a_count_max: assert property (p_count_max) else $error("pair count above limit");
   property p_preset1;
      @(posedge clk) disable iff (!rst_n)
      (scanTick && evTrue && st_reg.mode == EAS_RUN && st_reg.runSetting == eas_pkg::RUN_ON
         && st_reg.pairCount != 5'h0 && curAction == eas_pkg::ACT_PRESET1)
         |=> presetSel && presetStrobe;
   endproperty
   a_preset1: assert property (p_preset1) else $error("preset one not selected");
   property p_timer_done;
      @(posedge clk) disable iff (!rst_n)
      $fell(st_reg.timerOn) && !actionPulse |-> st_reg.timerDone;
   endproperty
   a_timer_done: assert property (p_timer_done) else $error("timer stop without done");
   c_action: cover property (@(posedge clk) disable iff (!rst_n) actionPulse);
   c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
      actionPulse ##1 stateIndex == 5'h0);
   c_timer: cover property (@(posedge clk) disable iff (!rst_n) $rose(st_reg.timerDone));
endmodule
`default_nettype wire

// ---- dv/eas_drive_model.sv ----
// drive speed model that ramps to reference after each preset change
`timescale 1ns/10ps
`default_nettype none
module eas_drive_model #(
   parameter int unsigned RAMP = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command from the sequencer
   input wire logic presetStrobe,
   // status back to the sequencer
   output logic onReference
);
   logic [7:0] rampReg;
   ////////////////////////////////////////////////////////////////////////
   // a new preset restarts the ramp, so reference is lost until it ends
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rampReg <= 8'h00;
      end else if (presetStrobe) begin
         rampReg <= 8'(RAMP);
      end else if (rampReg != 8'h00) begin
         rampReg <= rampReg - 8'h01;
      end
   end
   // level only true once the ramp counter has run out
   assign onReference = rst_n && (rampReg == 8'h00);
endmodule
`default_nettype wire

// ---- dv/eas_sequencer_tb_top.sv ----
// self-checking bench for the event action sequencer
`timescale 1ns/10ps
`default_nettype none
module eas_sequencer_tb_top;
   localparam int unsigned SCAN = 8;
   localparam int unsigned MSC = 4;
   logic clk, rst_n, cyc, stb, we, onRef, ack, pSel, pStrobe, tRun, actPulse;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] datW, datR, q;
   logic [4:0] idx;
   logic [7:0] evTab [4];
   logic [7:0] acTab [4];
   int nFail, cmpCount, gap;
   ////////////////////////////////////////////////////////////////////////
   // short scan and millisecond counts keep the run brief
   eas_sequencer #(.SCAN_CYCLES(SCAN), .MS_CYCLES(MSC)) dut_u (
      .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
      .wb_ack_o(ack), .onReference(onRef), .presetSel(pSel),
      .presetStrobe(pStrobe), .timerRunning(tRun), .actionPulse(actPulse),
      .stateIndex(idx)
   );
   eas_drive_model #(.RAMP(20)) drive_u (
      .clk(clk), .rst_n(rst_n), .presetStrobe(pStrobe), .onReference(onRef)
   );
   // free running 100 MHz clock
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   // verdict and end of run, also reached from any exhausted wait
   task automatic endSim;
      $display("comparisons %0d mismatches %0d", cmpCount, nFail);
      if (nFail == 0 && cmpCount > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         nFail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one classic wishbone cycle; request held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hf;
      adr <= a;
      datW <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         nFail++;
         endSim();
      end
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h00000000);
      chk(q, e);
   endtask
   // bounded wait for the next executed action; gap holds the cycles
   task automatic waitAct;
      gap = 0;
      do begin
         @(posedge clk);
         gap++;
      end while (actPulse !== 1'b1 && gap < 400);
      if (gap >= 400) begin
         nFail++;
         endSim();
      end
   endtask
   // no action may fire during the given number of cycles
   task automatic quiet(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(posedge clk);
         if (actPulse === 1'b1) c++;
      end
      chk(c, 0);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence: the start, hold, stop example and its corner cases
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'hf;
      datW = 32'h00000000;
      nFail = 0;
      cmpCount = 0;
      evTab = '{8'h01, 8'h04, 8'h1e, 8'h00};
      acTab = '{8'h0a, 8'h1d, 8'h0b, 8'h01};
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h00000000);
      rd(8'h08, 32'h000007d0);
      rd(8'h40, 32'h00000000);
      rd(8'h90, 32'h00000001);
      rd(8'h20, 32'h00000000);
      wr(8'h04, 32'h00000019);
      rd(8'h04, 32'h00000014);
      for (int i = 0; i < 4; i++) begin
         wr(8'h40 + 8'(4 * i), 32'(evTab[i]));
         wr(8'h90 + 8'(4 * i), 32'(acTab[i]));
      end
      rd(8'h48, 32'h0000001e);
      rd(8'h94, 32'h0000001d);
      wr(8'h08, 32'h00000002);
      rd(8'h08, 32'h00000002);
      wr(8'h04, 32'h00000004);
      wr(8'h00, 32'h00000001);
      waitAct();
      chk(idx, 1);
      chk({pStrobe, pSel}, {1'b1, 1'b0});
      waitAct();
      chk(32'(gap >= 20), 1);
      chk({tRun, idx}, {1'b1, 5'd2});
      waitAct();
      chk(32'(gap >= 2 * MSC), 1);
      chk({tRun, pStrobe, pSel, idx}, {1'b0, 1'b1, 1'b1, 5'd3});
      quiet(6 * SCAN);
      chk(idx, 3);
      rd(8'h0c, 32'h000002c3);
      wr(8'h4c, 32'h00000001);
      waitAct();
      chk({pStrobe, pSel, idx}, {1'b0, 1'b1, 5'd0});
      waitAct();
      chk({pStrobe, pSel, idx}, {1'b1, 1'b0, 5'd1});
      wr(8'h00, 32'h00000000);
      quiet(6 * SCAN);
      chk(idx, 0);
      wr(8'h04, 32'h00000000);
      wr(8'h00, 32'h00000001);
      quiet(6 * SCAN);
      // setting goes off before the count returns, so no run slips in between
      wr(8'h00, 32'h00000002);
      wr(8'h04, 32'h00000004);
      quiet(6 * SCAN);
      wr(8'h40, 32'h00000000);
      wr(8'h00, 32'h00000001);
      quiet(8 * SCAN);
      chk(idx, 0);
      // mid-run reset puts every setting and the table back to reset values
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h00, 32'h00000000);
      rd(8'h04, 32'h00000000);
      rd(8'h08, 32'h000007d0);
      rd(8'h4c, 32'h00000000);
      rd(8'h0c, 32'h00000000);
      endSim();
   end
endmodule
`default_nettype wire
